//--- sim/fpsbg_chk.sv
// port assertions of the front panel status and busy gating block
`default_nettype none
`include "fpsbg_defs.svh"
module fpsbg_chk (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // causes
    input wire logic wb_ack_o,
    input wire logic converting,
    input wire logic analogReset,
    input wire logic multiEventBufferFull,
    input wire logic eventsPresent,
    input wire logic [`FPSBG_TERM_N-1:0] termSwitchPos,
    input wire logic [`FPSBG_TERM_N-1:0] termSwitchNeg,
    input wire logic overcurrentDetect,
    // effects
    input wire logic sharedBusyOut,
    input wire logic sharedBusyOe,
    input wire logic acquisitionHalt,
    input wire logic ackIndicator,
    input wire logic busyIndicator,
    input wire logic eventAvailableIndicator,
    input wire logic termIndicatorGreen,
    input wire logic termIndicatorRed,
    input wire logic powerOvercurrentIndicatorGreen,
    input wire logic powerOvercurrentIndicatorOrange
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [`FPSBG_TERM_N-1:0] termOn = termSwitchPos & termSwitchNeg;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ****
    // lights
    // ****
    AST_ACK: assert property (wb_ack_o |-> ackIndicator [*8])
        else $error("ack light too short");
    AST_BUSY: assert property (
        converting || analogReset || multiEventBufferFull |=> busyIndicator)
        else $error("busy light missing");
    AST_EVT: assert property (
        eventsPresent |=> eventAvailableIndicator)
        else $error("event light missing");
    AST_CFG: assert property ($fell(srst) |-> (busyIndicator &&
        eventAvailableIndicator && termIndicatorGreen && termIndicatorRed) [*8])
        else $error("configuring pattern missing");
    AST_GREEN: assert property (
        termIndicatorGreen && !termIndicatorRed |-> &$past(termOn, 3))
        else $error("green without full termination");
    AST_RED: assert property (
        termIndicatorRed && !termIndicatorGreen |-> $past(termOn, 3) == 7'h00)
        else $error("red with some termination");
    AST_DARK: assert property (
        !termIndicatorGreen && !termIndicatorRed |->
        $past(termOn, 3) != 7'h00 && !(&$past(termOn, 3)))
        else $error("dark light without partial termination");
    AST_PWR: assert property ($past(overcurrentDetect, 3) |->
        powerOvercurrentIndicatorOrange && !powerOvercurrentIndicatorGreen)
        else $error("overcurrent not shown");
    // ****
    // busy line and halt
    // ****
    AST_OE: assert property (
        $rose(converting) |=> sharedBusyOe && sharedBusyOut)
        else $error("own busy not on shared line");
    AST_HALT: assert property (sharedBusyOe |-> acquisitionHalt)
        else $error("own busy without halt");
endmodule
`default_nettype wire

//--- sim/fpsbg_peer.sv
// peer boards sharing the wired-or busy line
`default_nettype none
module fpsbg_peer (
    // clock
    input wire logic clock,
    // peer and own busy
    input wire logic peerBusy,
    input wire logic ownOe,
    // resolved line, pulled low when nobody drives
    output logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic peerOe_q = 1'b0;
    always_ff @(posedge clock) peerOe_q <= peerBusy;
    assign line = ownOe | peerOe_q;
endmodule
`default_nettype wire

//--- sim/front_panel_status_and_busy_gating_test.sv
// self-checking bench of the front panel status and busy gating block
`default_nettype none
module front_panel_status_and_busy_gating_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fpsbg_pkg::*;
    logic clock = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, converting = 0, analogReset = 0, multiEventBufferFull = 0;
    logic eventsPresent = 0, busyScopeJumper = 0, overcurrentDetect = 0;
    logic [15:0] rotarySwitch = 16'h3a5c, baseAddress;
    logic [6:0] termSwitchPos = 7'h7f, termSwitchNeg = 7'h7f;
    logic sharedBusyIn, sharedBusyOut, sharedBusyOe, peerBusy = 0;
    logic ackIndicator, busyIndicator, eventAvailableIndicator, irq;
    logic termIndicatorGreen, termIndicatorRed, acquisitionHalt;
    logic powerOvercurrentIndicatorGreen, powerOvercurrentIndicatorOrange;
    int num_errors = 0, n_checks = 0, cycles = 0;
    always #50 clock = ~clock;
    fpsbg_top #(.CFG_CYCLES(20), .ACK_CYCLES(8)) fpsbg_top_inst (
        .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .converting(converting),
        .analogReset(analogReset),
        .multiEventBufferFull(multiEventBufferFull),
        .eventsPresent(eventsPresent), .rotarySwitch(rotarySwitch),
        .termSwitchPos(termSwitchPos), .termSwitchNeg(termSwitchNeg),
        .busyScopeJumper(busyScopeJumper),
        .overcurrentDetect(overcurrentDetect),
        .sharedBusyIn(sharedBusyIn), .sharedBusyOut(sharedBusyOut),
        .sharedBusyOe(sharedBusyOe), .ackIndicator(ackIndicator),
        .busyIndicator(busyIndicator),
        .eventAvailableIndicator(eventAvailableIndicator),
        .termIndicatorGreen(termIndicatorGreen),
        .termIndicatorRed(termIndicatorRed),
        .powerOvercurrentIndicatorGreen(powerOvercurrentIndicatorGreen),
        .powerOvercurrentIndicatorOrange(powerOvercurrentIndicatorOrange),
        .baseAddress(baseAddress), .acquisitionHalt(acquisitionHalt),
        .irq(irq));
    fpsbg_peer fpsbg_peer_inst (.clock(clock), .peerBusy(peerBusy),
        .ownOe(sharedBusyOe), .line(sharedBusyIn));
    // ****
    // shared tasks
    // ****
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // single classic cycle; waits for ack without assuming a latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clock);
        while (wb_ack_o !== 1'b1) @(posedge clock);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clock);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_cfg;
        tick(2);
        chk({busyIndicator, eventAvailableIndicator, termIndicatorGreen,
            termIndicatorRed}, 4'hf);
        wb(0, 8'h00, 32'h0);
        chk(rd[4], 1'b1);
        tick(25);
        chk({busyIndicator, eventAvailableIndicator, termIndicatorGreen,
            termIndicatorRed, powerOvercurrentIndicatorGreen,
            powerOvercurrentIndicatorOrange}, 6'h0a);
        wb(0, 8'h04, 32'h0);
        chk(rd[3], 1'b1);
    endtask
    task automatic t_ack;
        wb(0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(ackIndicator, 1'b1);
        tick(10);
        chk(ackIndicator, 1'b0);
    endtask
    task automatic t_busy;
        for (int i = 0; i < 4; i++) begin
            {multiEventBufferFull, analogReset, converting} <= 3'b001 << i;
            if (i == 3) wb(1, 8'h14, 32'h1);
            tick(3);
            chk(busyIndicator, 1'b1);
            chk(sharedBusyOe, 1'b1);
            chk(acquisitionHalt, 1'b1);
            {multiEventBufferFull, analogReset, converting} <= 3'b000;
            wb(1, 8'h14, 32'h0);
            tick(3);
            chk(busyIndicator, 1'b0);
        end
    endtask
    task automatic t_evt;
        wb(1, 8'h08, 32'h1f);
        wb(1, 8'h0c, 32'h2);
        eventsPresent <= 1;
        tick(3);
        chk(eventAvailableIndicator, 1'b1);
        chk(irq, 1'b1);
        wb(1, 8'h0c, 32'h0);
        tick(2);
        chk(irq, 1'b0);
        wb(1, 8'h0c, 32'h2);
        wb(1, 8'h08, 32'h2);
        tick(2);
        chk(irq, 1'b0);
        eventsPresent <= 0;
        tick(3);
        chk(eventAvailableIndicator, 1'b0);
    endtask
    task automatic t_term;
        logic [13:0] pat [4] = '{14'h3fff, 14'h0000, 14'h3f80, 14'h3f81};
        logic [1:0] exp [4] = '{2'b10, 2'b01, 2'b01, 2'b00};
        for (int i = 0; i < 4; i++) begin
            {termSwitchPos, termSwitchNeg} <= pat[i];
            tick(5);
            chk({termIndicatorGreen, termIndicatorRed}, exp[i]);
        end
    endtask
    task automatic t_shared;
        peerBusy <= 1;
        busyScopeJumper <= 1;
        tick(6);
        chk(acquisitionHalt, 1'b1);
        wb(0, 8'h00, 32'h0);
        chk(rd[3:2], 2'b10);
        busyScopeJumper <= 0;
        tick(6);
        chk(acquisitionHalt, 1'b0);
        peerBusy <= 0;
        tick(6);
        wb(0, 8'h00, 32'h0);
        chk(rd[3], 1'b0);
    endtask
    task automatic t_pwr;
        chk(baseAddress, 16'h3a5c);
        wb(0, 8'h10, 32'h0);
        chk(rd, 32'h3a5c);
        overcurrentDetect <= 1;
        tick(5);
        overcurrentDetect <= 0;
        tick(5);
        chk({powerOvercurrentIndicatorGreen,
            powerOvercurrentIndicatorOrange}, 2'b01);
    endtask
    initial begin
        tick(5);
        srst <= 0;
        t_cfg();
        t_ack();
        t_busy();
        t_evt();
        t_term();
        t_shared();
        t_pwr();
        end_of_test();
    end
endmodule
bind fpsbg_top fpsbg_chk fpsbg_chk_inst (.clock(clock), .srst(srst),
    .wb_ack_o(wb_ack_o), .converting(converting),
    .analogReset(analogReset), .multiEventBufferFull(multiEventBufferFull),
    .eventsPresent(eventsPresent), .termSwitchPos(termSwitchPos),
    .termSwitchNeg(termSwitchNeg), .overcurrentDetect(overcurrentDetect),
    .sharedBusyOut(sharedBusyOut), .sharedBusyOe(sharedBusyOe),
    .acquisitionHalt(acquisitionHalt), .ackIndicator(ackIndicator),
    .busyIndicator(busyIndicator),
    .eventAvailableIndicator(eventAvailableIndicator),
    .termIndicatorGreen(termIndicatorGreen),
    .termIndicatorRed(termIndicatorRed),
    .powerOvercurrentIndicatorGreen(powerOvercurrentIndicatorGreen),
    .powerOvercurrentIndicatorOrange(powerOvercurrentIndicatorOrange));
`default_nettype wire

//--- verilog/fpsbg_defs.svh
// constants of the front panel status and busy gating block
`ifndef FPSBG_DEFS_SVH
`define FPSBG_DEFS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FPSBG_REG_STATUS 8'h00
`define FPSBG_REG_IRQ_STAT 8'h04
`define FPSBG_REG_IRQ_CLR 8'h08
`define FPSBG_REG_IRQ_EN 8'h0c
`define FPSBG_REG_BASE 8'h10
`define FPSBG_REG_CTRL 8'h14

// ****************************************
// field positions
// ****************************************
`define FPSBG_ST_EVT 0
`define FPSBG_ST_LBUSY 2
`define FPSBG_ST_SBUSY 3
`define FPSBG_ST_CFG 4
`define FPSBG_ST_OVC 5
`define FPSBG_ST_HALT 6
`define FPSBG_IRQ_BUSY 0
`define FPSBG_IRQ_EVT 1
`define FPSBG_IRQ_OVC 2
`define FPSBG_IRQ_CFG 3
`define FPSBG_IRQ_SBUSY 4
`define FPSBG_IRQ_W 5
`define FPSBG_CTRL_MEMTEST 0

// ****************************************
// reset values and widths
// ****************************************
`define FPSBG_IRQ_EN_RST 5'h00
`define FPSBG_CTRL_RST 1'b0
`define FPSBG_PIN_W 33
`define FPSBG_TERM_N 7
`define FPSBG_CNT_W 24

// ****************************************
// timing
// ****************************************
`define FPSBG_CLK_HZ 10000000
`define FPSBG_CFG_TIME_MS 500
`define FPSBG_ACK_TIME_MS 50
`define FPSBG_CFG_CYCLES (`FPSBG_CFG_TIME_MS * (`FPSBG_CLK_HZ / 1000))
`define FPSBG_ACK_CYCLES (`FPSBG_ACK_TIME_MS * (`FPSBG_CLK_HZ / 1000))

`endif

//--- verilog/fpsbg_pkg.sv
// types of the front panel status and busy gating block
`default_nettype none
`include "fpsbg_defs.svh"
package fpsbg_pkg;
    typedef enum logic [1:0] {
        FPSBG_CFG = 2'b01,
        FPSBG_RUN = 2'b10
    } fpsbg_cfg_e;

    typedef logic [`FPSBG_CNT_W-1:0] fpsbg_cnt_t;
    typedef logic [`FPSBG_IRQ_W-1:0] fpsbg_irq_t;

    typedef struct packed {
        logic [`FPSBG_PIN_W-1:0] pinMeta;
        logic [`FPSBG_PIN_W-1:0] pinSync;
        fpsbg_cfg_e cfgState;
        fpsbg_cnt_t cfgCnt;
        fpsbg_cnt_t ackCnt;
        logic ovcLatched;
        logic memTest;
        fpsbg_irq_t irqStat;
        fpsbg_irq_t irqEn;
        logic prevBusy;
        logic prevEvt;
        logic prevSBusy;
        logic wbAck;
        logic [31:0] wbDat;
        logic ackLed;
        logic busyLed;
        logic evtLed;
        logic termGreen;
        logic termRed;
        logic pwrGreen;
        logic pwrOrange;
        logic busyLineOe;
        logic acqHalt;
        logic irq;
        logic [15:0] baseAddr;
    } fpsbg_state_s;
endpackage
`default_nettype wire

//--- verilog/fpsbg_top.sv
// front panel indicators, board options and busy gating
`default_nettype none
`include "fpsbg_defs.svh"
module fpsbg_top #(
    parameter int CFG_CYCLES = `FPSBG_CFG_CYCLES,
    parameter int ACK_CYCLES = `FPSBG_ACK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,

    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,

    // acquisition state, same clock
    input wire logic converting,
    input wire logic analogReset,
    input wire logic multiEventBufferFull,
    input wire logic eventsPresent,

    // board pins, asynchronous
    input wire logic [15:0] rotarySwitch,
    input wire logic [`FPSBG_TERM_N-1:0] termSwitchPos,
    input wire logic [`FPSBG_TERM_N-1:0] termSwitchNeg,
    input wire logic busyScopeJumper,
    input wire logic overcurrentDetect,
    input wire logic sharedBusyIn,

    // shared busy line, open drain
    output logic sharedBusyOut,
    output logic sharedBusyOe,

    // front panel lights
    output logic ackIndicator,
    output logic busyIndicator,
    output logic eventAvailableIndicator,
    output logic termIndicatorGreen,
    output logic termIndicatorRed,
    output logic powerOvercurrentIndicatorGreen,
    output logic powerOvercurrentIndicatorOrange,

    // board outputs
    output logic [15:0] baseAddress,
    output logic acquisitionHalt,
    output logic irq
);
    import fpsbg_pkg::*;

    // ****************************************
    // counts and reset value
    // ****************************************
    localparam fpsbg_cnt_t CFG_LOAD = fpsbg_cnt_t'(CFG_CYCLES - 1);
    localparam fpsbg_cnt_t ACK_LOAD = fpsbg_cnt_t'(ACK_CYCLES);

    fpsbg_state_s q;
    fpsbg_state_s d;

    // ****************************************
    // pin vector layout
    // ****************************************
    // two flops per pin, logic only ever reads the second one
    logic [`FPSBG_PIN_W-1:0] pinRaw;
    assign pinRaw = {sharedBusyIn, overcurrentDetect, busyScopeJumper,
                     termSwitchNeg, termSwitchPos, rotarySwitch};

    logic [15:0] rotSync;
    logic [`FPSBG_TERM_N-1:0] posSync;
    logic [`FPSBG_TERM_N-1:0] negSync;
    logic jumperSync;
    logic ovcSync;
    logic sBusySync;
    assign rotSync = q.pinSync[15:0];
    assign posSync = q.pinSync[22:16];
    assign negSync = q.pinSync[29:23];
    assign jumperSync = q.pinSync[30];
    assign ovcSync = q.pinSync[31];
    assign sBusySync = q.pinSync[32];

    // ****************************************
    // termination per line
    // ****************************************
    // a line only counts as terminated when both halves of its pair are set
    logic [`FPSBG_TERM_N-1:0] lineTerm;
    genvar gi;
    generate
        for (gi = 0; gi < `FPSBG_TERM_N; gi++) begin : gTerm
            assign lineTerm[gi] = posSync[gi] & negSync[gi];
        end
    endgenerate

    logic allTerm;
    logic noTerm;
    assign allTerm = &lineTerm;
    assign noTerm = ~|lineTerm;

    // ****************************************
    // bus decode
    // ****************************************
    logic wbReq;
    logic wbWr;
    logic wbRd;
    // the registered ack masks a held request, so it is answered once
    assign wbReq = wb_cyc_i & wb_stb_i & ~q.wbAck;
    assign wbWr = wbReq & wb_we_i & wb_sel_i[0];
    assign wbRd = wbReq & ~wb_we_i;

    // ****************************************
    // register writes
    // ****************************************
    // only lane 0 holds writable bits; unmapped writes are acked and lost
    logic wrIrqClr;
    logic wrIrqEn;
    logic wrCtrl;
    assign wrIrqClr = wbWr && wb_adr_i == `FPSBG_REG_IRQ_CLR;
    assign wrIrqEn = wbWr && wb_adr_i == `FPSBG_REG_IRQ_EN;
    assign wrCtrl = wbWr && wb_adr_i == `FPSBG_REG_CTRL;

    logic localBusy;
    logic configuring;
    logic [31:0] statusWord;
    logic [31:0] rdWord;
    fpsbg_irq_t irqEvents;
    fpsbg_irq_t irqClr;

    assign configuring = q.cfgState == FPSBG_CFG;
    assign localBusy = converting | analogReset | q.memTest
                     | multiEventBufferFull;

    always_comb begin
        statusWord = 32'h00000000;
        statusWord[`FPSBG_ST_EVT] = eventsPresent;
        statusWord[`FPSBG_ST_LBUSY] = localBusy;
        statusWord[`FPSBG_ST_SBUSY] = sBusySync;
        statusWord[`FPSBG_ST_CFG] = configuring;
        statusWord[`FPSBG_ST_OVC] = q.ovcLatched;
        statusWord[`FPSBG_ST_HALT] = q.acqHalt;
    end

    always_comb begin
        case (wb_adr_i)
            `FPSBG_REG_STATUS: rdWord = statusWord;
            `FPSBG_REG_IRQ_STAT: rdWord = {27'h0000000, q.irqStat};
            `FPSBG_REG_IRQ_EN: rdWord = {27'h0000000, q.irqEn};
            `FPSBG_REG_BASE: rdWord = {16'h0000, q.baseAddr};
            `FPSBG_REG_CTRL: rdWord = {31'h00000000, q.memTest};
            default: rdWord = 32'h00000000;
        endcase
    end

    // ****************************************
    // interrupt events
    // ****************************************
    always_comb begin
        irqEvents = '0;
        irqEvents[`FPSBG_IRQ_BUSY] = localBusy & ~q.prevBusy;
        irqEvents[`FPSBG_IRQ_EVT] = eventsPresent & ~q.prevEvt;
        irqEvents[`FPSBG_IRQ_OVC] = ovcSync & ~q.ovcLatched;
        irqEvents[`FPSBG_IRQ_CFG] = configuring && q.cfgCnt == '0;
        irqEvents[`FPSBG_IRQ_SBUSY] = sBusySync & ~q.prevSBusy;
    end

    assign irqClr = wrIrqClr ? wb_dat_i[`FPSBG_IRQ_W-1:0] : '0;

    // ****************************************
    // sticky interrupt bits
    // ****************************************
    // a new event wins over a clear that lands in the same cycle
    fpsbg_irq_t irqNext;
    genvar ii;
    generate
        for (ii = 0; ii < `FPSBG_IRQ_W; ii++) begin : gIrq
            assign irqNext[ii] = irqEvents[ii]
                               | (q.irqStat[ii] & ~irqClr[ii]);
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.pinMeta = pinRaw;
        d.pinSync = q.pinMeta;

        // bus answer one cycle after the request, dropped the cycle after
        d.wbAck = wbReq;
        d.wbDat = wbRd ? rdWord : 32'h00000000;
        if (wrIrqEn) begin
            d.irqEn = wb_dat_i[`FPSBG_IRQ_W-1:0];
        end
        if (wrCtrl) begin
            d.memTest = wb_dat_i[`FPSBG_CTRL_MEMTEST];
        end

        d.irqStat = irqNext;
        d.prevBusy = localBusy;
        d.prevEvt = eventsPresent;
        d.prevSBusy = sBusySync;
        d.irq = |(d.irqStat & d.irqEn);

        // every access reloads the flash timer
        // back-to-back accesses just restart the flash, so it never flickers
        if (wbReq) begin
            d.ackCnt = ACK_LOAD;
        end else if (q.ackCnt != '0) begin
            d.ackCnt = q.ackCnt - 1'b1;
        end
        d.ackLed = wbReq | (q.ackCnt > fpsbg_cnt_t'(1));

        case (q.cfgState)
            FPSBG_CFG: begin
                if (q.cfgCnt == '0) begin
                    d.cfgState = FPSBG_RUN;
                end else begin
                    d.cfgCnt = q.cfgCnt - 1'b1;
                end
            end
            FPSBG_RUN: begin
                d.cfgCnt = '0;
            end
            default: begin
                d.cfgState = FPSBG_CFG;
                d.cfgCnt = CFG_LOAD;
            end
        endcase

        // cleared only by srst, so the module must be reset to clear it
        if (ovcSync) begin
            d.ovcLatched = 1'b1;
        end

        d.baseAddr = rotSync;
        d.busyLineOe = localBusy;

        // configuration neither halts acquisition nor drives the line
        // the shared line already includes this board's own drive
        if (jumperSync) begin
            d.acqHalt = localBusy | sBusySync;
        end else begin
            d.acqHalt = localBusy;
        end

        if (d.cfgState == FPSBG_CFG) begin
            d.busyLed = 1'b1;
            d.evtLed = 1'b1;
            d.termGreen = 1'b1;
            d.termRed = 1'b1;
        end else begin
            d.busyLed = localBusy;
            d.evtLed = eventsPresent;
            d.termGreen = allTerm;
            d.termRed = noTerm;
            // partial termination leaves both colours off
        end

        // green comes back only after a reset, as the latch does
        d.pwrGreen = ~d.ovcLatched;
        d.pwrOrange = d.ovcLatched;

        if (srst) begin
            d = '0;
            d.cfgState = FPSBG_CFG;
            d.cfgCnt = CFG_LOAD;
            d.irqEn = `FPSBG_IRQ_EN_RST;
            d.memTest = `FPSBG_CTRL_RST;
            d.busyLed = 1'b1;
            d.evtLed = 1'b1;
            d.termGreen = 1'b1;
            d.termRed = 1'b1;
            d.pwrGreen = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output is a plain flop of the state, no logic after it
    assign wb_dat_o = q.wbDat;
    assign wb_ack_o = q.wbAck;
    assign sharedBusyOut = q.busyLineOe;
    assign sharedBusyOe = q.busyLineOe;
    assign ackIndicator = q.ackLed;
    assign busyIndicator = q.busyLed;
    assign eventAvailableIndicator = q.evtLed;
    assign termIndicatorGreen = q.termGreen;
    assign termIndicatorRed = q.termRed;
    assign powerOvercurrentIndicatorGreen = q.pwrGreen;
    assign powerOvercurrentIndicatorOrange = q.pwrOrange;
    assign baseAddress = q.baseAddr;
    assign acquisitionHalt = q.acqHalt;
    assign irq = q.irq;
endmodule
`default_nettype wire
